// file: dv/reference_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, v); end end
module reference_mode_control_bench;
  import rmc_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, conv = 1'b0, done = 1'b0;
  logic       dir = 1'b1, val = 1'b1, chop, pump, ref_a, ext_b, pb, pb_oe;
  logic [1:0] ex = 2'h0;
  logic [3:0] per;
  logic [7:0] d, rd_data, rd_addr;
  rmc_wr_s    wr;
  int         n_errors = 0, checked = 0;
  rmc_host i_rmc_host (.clk_in(clk), .rd_data_in(rd_data), .wr_out(wr),
    .rd_addr_out(rd_addr));
  rmc_mode_ctrl i_rmc_mode_ctrl (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .WR_IN(wr), .RD_ADDR_IN(rd_addr), .RD_DATA_OUT(rd_data),
    .CONV_ACTIVE_IN(conv), .ELEM_DONE_IN(done),
    .ELEM_COUNT_EXPONENT_IN(ex), .PAD_B_DIRECTION_IN(dir),
    .PAD_B_OUTPUT_VALUE_IN(val), .CHOP_STATE_OUT(chop),
    .PUMP_ENABLE_OUT(pump), .REF_OUT_ON_PAD_A_OUT(ref_a),
    .EXT_REF_FROM_PAD_B_OUT(ext_b), .PAD_B_OUT(pb), .PAD_B_OE_OUT(pb_oe),
    .ELEM_PER_CONV_OUT(per));
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // chop is registered from the code, so allow one edge after the write
  task automatic setm(input logic [7:0] m);
    i_rmc_host.wr(8'h70, m);
    @(negedge clk);
  endtask : setm
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
    end
  endtask : pulse
  initial forever #5 clk = ~clk;
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    i_rmc_host.rd(8'h70, d);
    `CHK("mode", 8'h84, d)
    `CHK("pump", 1'b0, pump)
    `CHK("pads", 2'h0, {ref_a, ext_b})
    for (int i = 0; i < 4; i++) begin
      setm(8'(i << 2));
      `CHK("pump", i != 1, pump)
    end
    i_rmc_host.wr(8'h71, 8'h04);
    i_rmc_host.rd(8'h71, d);
    `CHK("unmapped", 9'h100, {pump, d})
    setm(8'hff);
    i_rmc_host.rd(8'h70, d);
    `CHK("mode", 8'hbf, d)
    `CHK("pads", 4'hc, {ref_a, ext_b, pb_oe, pb})
    setm(8'h00);
    `CHK("pad b", 4'h3, {ref_a, ext_b, pb_oe, pb})
    for (int e = 0; e < 4; e++) begin
      ex = 2'(e);
      #1 `CHK("count", 4'(1 << e), per)
    end
    conv = 1'b1;
    pulse(1);
    `CHK("chop", 1'b0, chop)
    setm(8'h10);
    `CHK("chop", 1'b1, chop)
    setm(8'h20);
    pulse(1);
    `CHK("chop", 1'b0, chop)
    pulse(1);
    `CHK("chop", 1'b1, chop)
    conv = 1'b0;
    setm(8'h30);
    conv = 1'b1;
    pulse(1);
    `CHK("chop", 1'b1, chop)
    pulse(1);
    `CHK("chop", 1'b0, chop)
    conv = 1'b0;
    pulse(2);
    `CHK("idle chop", 1'b0, chop)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    i_rmc_host.rd(8'h70, d);
    `CHK("reset mode", 8'h84, d)
    `CHK("reset pump", 1'b0, pump)
    tally_and_finish();
  end
endmodule : reference_mode_control_bench
`default_nettype wire

// file: dv/rmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_host
  import rmc_pkg::*;
(
  // bus side
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  output var  rmc_wr_s    wr_out,
  output logic      [7:0] rd_addr_out
);
  // pump stays forced off unless a write asks otherwise
  initial wr_out = '0;
  initial rd_addr_out = 8'h00;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = '{we: 1'b1, addr: a, wdata: d};
    @(negedge clk_in);
    wr_out.we = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_addr_out = a;
    #1 d = rd_data_in;
  endtask : rd
endmodule : rmc_host
`default_nettype wire

// file: rtl/rmc_mode_ctrl.sv
// Behaviour
// - chop code 00 holds chop at 0 and code 01 holds it at 1.
// - code 10 toggles chop each elementary conversion, 11 every second.
// - pump force-on turns the pump on whatever force-off says.
// - force-off alone keeps the pump off and resets to 1.
// - reference-out enable puts the reference on pad a, resets to 0.
// - external-reference enable takes reference from pad b, resets 0.
// - pad b output value applies only if output and no external ref.
// - elementary conversions per conversion are 2 to the exponent.
`include "rmc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rmc_mode_ctrl
  import rmc_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  // register port
  input  wire rmc_wr_s    WR_IN,
  input  wire logic [7:0] RD_ADDR_IN,
  output logic      [7:0] RD_DATA_OUT,
  // conversion sequencer
  input  wire logic       CONV_ACTIVE_IN,
  input  wire logic       ELEM_DONE_IN,
  input  wire logic [1:0] ELEM_COUNT_EXPONENT_IN,
  // pad b gpio
  input  wire logic       PAD_B_DIRECTION_IN,
  input  wire logic       PAD_B_OUTPUT_VALUE_IN,
  // analog controls
  output logic            CHOP_STATE_OUT,
  output logic            PUMP_ENABLE_OUT,
  output logic            REF_OUT_ON_PAD_A_OUT,
  output logic            EXT_REF_FROM_PAD_B_OUT,
  output logic            PAD_B_OUT,
  output logic            PAD_B_OE_OUT,
  output logic [3:0]      ELEM_PER_CONV_OUT
);
  rmc_state_s st;
  rmc_state_s next_st;
  logic [1:0] code;

  // write strobe decode, shared by the update logic and the checks
  function automatic logic mode_hit(input rmc_wr_s w);
    return w.we && (w.addr == `RMC_MODE_ADDR);
  endfunction : mode_hit

  assign code = st.mode[`RMC_CHOP_HI:`RMC_CHOP_LO];

  always_comb begin
    next_st = st;
    if (mode_hit(WR_IN)) begin
      // top bits are read-only
      next_st.mode = (st.mode & ~`RMC_MODE_WMASK)
                   | (WR_IN.wdata & `RMC_MODE_WMASK);
    end
    unique case (code)
      `RMC_CHOP_LOW: begin
        next_st.chop = 1'b0;
        next_st.half_phase = 1'b0;
      end
      `RMC_CHOP_HIGH: begin
        next_st.chop = 1'b1;
        next_st.half_phase = 1'b0;
      end
      `RMC_CHOP_FULL: begin
        if (!CONV_ACTIVE_IN) next_st.half_phase = 1'b0;
        else if (ELEM_DONE_IN) next_st.chop = ~st.chop;
      end
      `RMC_CHOP_HALF: begin
        if (!CONV_ACTIVE_IN) begin
          next_st.half_phase = 1'b0;
        end else if (ELEM_DONE_IN) begin
          next_st.half_phase = ~st.half_phase;
          if (st.half_phase) next_st.chop = ~st.chop;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      st.mode <= `RMC_MODE_RESET;
      st.chop <= 1'b0;
      st.half_phase <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // other addresses read as zero so a host scan sees no ghost register
  assign RD_DATA_OUT = (RD_ADDR_IN == `RMC_MODE_ADDR) ? st.mode
                                                     : `RMC_READ_IDLE;
  assign CHOP_STATE_OUT = st.chop;
  // force-on wins over force-off
  assign PUMP_ENABLE_OUT = st.mode[`RMC_PUMP_ON_BIT]
                         | ~st.mode[`RMC_PUMP_OFF_BIT];
  assign REF_OUT_ON_PAD_A_OUT = st.mode[`RMC_REF_OUT_BIT];
  assign EXT_REF_FROM_PAD_B_OUT = st.mode[`RMC_EXT_REF_BIT];
  // external ref owns pad b, so the gpio driver must let go
  assign PAD_B_OE_OUT = PAD_B_DIRECTION_IN
                      & ~st.mode[`RMC_EXT_REF_BIT];
  assign PAD_B_OUT = PAD_B_OE_OUT & PAD_B_OUTPUT_VALUE_IN;
  assign ELEM_PER_CONV_OUT = `RMC_ELEM_ONE
                           << ELEM_COUNT_EXPONENT_IN;

  a_pump_priority: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    st.mode[`RMC_PUMP_ON_BIT] |-> PUMP_ENABLE_OUT)
    else $error("pump off while forced on");

  a_pump_forced_off: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (st.mode[`RMC_PUMP_OFF_BIT] && !st.mode[`RMC_PUMP_ON_BIT])
    |-> !PUMP_ENABLE_OUT)
    else $error("pump on while forced off");

  a_pump_released: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (!st.mode[`RMC_PUMP_OFF_BIT] && !st.mode[`RMC_PUMP_ON_BIT])
    |-> PUMP_ENABLE_OUT)
    else $error("pump off with no force bit");

  a_chop_static: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code == `RMC_CHOP_LOW) |=> !CHOP_STATE_OUT)
    else $error("chop not held low");

  a_chop_high: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code == `RMC_CHOP_HIGH) |=> CHOP_STATE_OUT)
    else $error("chop not held high");

  a_chop_toggle: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code == `RMC_CHOP_FULL && CONV_ACTIVE_IN && ELEM_DONE_IN
     && !mode_hit(WR_IN))
    |=> CHOP_STATE_OUT != $past(CHOP_STATE_OUT))
    else $error("chop did not toggle");

  a_half_hold: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code == `RMC_CHOP_HALF && CONV_ACTIVE_IN && ELEM_DONE_IN
     && !st.half_phase)
    |=> $stable(CHOP_STATE_OUT))
    else $error("half rate chop toggled early");

  a_half_flip: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code == `RMC_CHOP_HALF && CONV_ACTIVE_IN && ELEM_DONE_IN
     && st.half_phase)
    |=> CHOP_STATE_OUT != $past(CHOP_STATE_OUT))
    else $error("half rate chop did not toggle");

  a_chop_idle: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (code[1] && !CONV_ACTIVE_IN) |=> $stable(CHOP_STATE_OUT))
    else $error("chop moved while idle");

  a_phase_idle: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    !CONV_ACTIVE_IN |=> !st.half_phase)
    else $error("half rate phase kept while idle");

  a_pad_b_gate: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    EXT_REF_FROM_PAD_B_OUT |-> !PAD_B_OE_OUT)
    else $error("pad b driven with external ref");

  a_pad_b_value: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    PAD_B_OUT == (PAD_B_DIRECTION_IN && !st.mode[`RMC_EXT_REF_BIT]
                  && PAD_B_OUTPUT_VALUE_IN))
    else $error("pad b value not gated");

  a_ref_out_map: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    mode_hit(WR_IN)
    |=> REF_OUT_ON_PAD_A_OUT == $past(WR_IN.wdata[`RMC_REF_OUT_BIT]))
    else $error("ref out enable not written");

  a_ext_ref_map: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    mode_hit(WR_IN)
    |=> EXT_REF_FROM_PAD_B_OUT == $past(WR_IN.wdata[`RMC_EXT_REF_BIT]))
    else $error("ext ref enable not written");

  a_read_other: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (RD_ADDR_IN != `RMC_MODE_ADDR) |-> RD_DATA_OUT == `RMC_READ_IDLE)
    else $error("unmapped read not zero");

  a_reserved_bits: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    (st.mode & ~`RMC_MODE_WMASK) == (`RMC_MODE_RESET & ~`RMC_MODE_WMASK))
    else $error("read-only bits changed");

  a_elem_count: assert property (
    @(posedge CLK_IN)
    disable iff (!RESET_N_IN)
    $onehot(ELEM_PER_CONV_OUT)
    && ELEM_PER_CONV_OUT[ELEM_COUNT_EXPONENT_IN])
    else $error("elementary count wrong");

  c_full_toggle: cover property (@(posedge CLK_IN)
    code == `RMC_CHOP_FULL && CONV_ACTIVE_IN && ELEM_DONE_IN);

  c_half_toggle: cover property (@(posedge CLK_IN)
    code == `RMC_CHOP_HALF && CONV_ACTIVE_IN && ELEM_DONE_IN
    && st.half_phase);

  c_pump_on: cover property (@(posedge CLK_IN) PUMP_ENABLE_OUT);

  c_idle_hold: cover property (@(posedge CLK_IN)
    code[1] && !CONV_ACTIVE_IN && ELEM_DONE_IN);

  c_ext_ref: cover property (@(posedge CLK_IN)
    EXT_REF_FROM_PAD_B_OUT && PAD_B_DIRECTION_IN);
endmodule : rmc_mode_ctrl
`default_nettype wire

// file: shared/rmc_pkg.sv
`default_nettype none
package rmc_pkg;
  typedef struct packed {
    logic [7:0] mode;
    logic       chop;
    logic       half_phase;
  } rmc_state_s;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmc_wr_s;
endpackage : rmc_pkg
`default_nettype wire

// file: shared/rmc_regs.svh
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH
`define RMC_MODE_ADDR      8'h70
`define RMC_MODE_RESET     8'h84
`define RMC_MODE_WMASK     8'h3f
`define RMC_CHOP_HI        5
`define RMC_CHOP_LO        4
`define RMC_PUMP_ON_BIT    3
`define RMC_PUMP_OFF_BIT   2
`define RMC_REF_OUT_BIT    1
`define RMC_EXT_REF_BIT    0
`define RMC_CHOP_LOW       2'h0
`define RMC_CHOP_HIGH      2'h1
`define RMC_CHOP_FULL      2'h2
`define RMC_CHOP_HALF      2'h3
`define RMC_READ_IDLE      8'h00
`define RMC_ELEM_ONE       4'h1
`endif
